// file: hdl/ubc_pkg.sv
package ubc_pkg;

  // Register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_BAUD   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK   = 8'h0c;
  localparam logic [7:0] OFS_TXDATA = 8'h10;
  localparam logic [7:0] OFS_RXDATA = 8'h14;
  localparam logic [7:0] OFS_STATE  = 8'h18;

  // Control register field positions.
  localparam int CTRL_W        = 7;
  localparam int CB_PORT_EN    = 0;
  localparam int CB_TX_EN      = 1;
  localparam int CB_RX_EN      = 2;
  localparam int CB_NINE_BIT   = 3;
  localparam int CB_ADDR_DET   = 4;
  localparam int CB_HIGH_SPEED = 5;
  localparam int CB_RX_IRQ_EN  = 6;

  // Sticky status and mask field positions.
  localparam int ST_W         = 4;
  localparam int SB_RX_AVAIL  = 0;
  localparam int SB_OVERRUN   = 1;
  localparam int SB_ADDR_RCVD = 2;
  localparam int SB_TX_EMPTY  = 3;

  // Reset values.
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  localparam logic [7:0]        BAUD_RST = 8'h00;
  localparam logic [ST_W-1:0]   MASK_RST = 4'h0;

  // Timing: sample ticks per bit and low speed prescale.
  localparam int            OVERSAMPLE = 16;
  localparam int            HALF_BIT   = OVERSAMPLE / 2;
  localparam int            LOW_PRESC  = 4;
  localparam logic [1:0]    PRESC_LAST = 2'(LOW_PRESC - 1);
  localparam logic [3:0]    TICK_LAST  = 4'(OVERSAMPLE - 1);
  localparam logic [3:0]    TICK_MID   = 4'(HALF_BIT - 1);

  // AHB transfer type bit that marks an active transfer.
  localparam int HTRANS_ACTIVE = 1;

endpackage

// file: hdl/ubc_baud_gen.sv
`timescale 1ns/1ns
// Free running divisor timer giving one sample tick per sixteenth of a bit.
module ubc_baud_gen #(
  parameter int DIV_W = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             clear,
  input  wire logic             high_speed,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  sample_tick
);

  logic [DIV_W-1:0] cnt_ff;
  logic [DIV_W-1:0] nxt_cnt;
  logic [1:0]       presc_ff;
  logic [1:0]       nxt_presc;
  logic             tick_ff;
  logic             nxt_tick;

  if (DIV_W < 1) begin : g_chk
    $error("ubc_baud_gen: DIV_W must be at least 1");
  end

  // Count down to zero, reload the divisor and pace a tick; low speed adds a divide by four.
  always_comb begin
    nxt_cnt   = cnt_ff - 1'b1;
    nxt_presc = presc_ff;
    nxt_tick  = 1'b0;
    if (clear) begin
      nxt_cnt   = divisor;
      nxt_presc = 2'h0;
    end else if (cnt_ff == '0) begin
      nxt_cnt   = divisor;
      nxt_presc = presc_ff + 2'h1;
      nxt_tick  = high_speed || (presc_ff == ubc_pkg::PRESC_LAST);
      if (high_speed) begin
        nxt_presc = 2'h0;
      end
    end
  end

  // Registers of the timer.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_ff   <= '0;
      presc_ff <= 2'h0;
      tick_ff  <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      presc_ff <= nxt_presc;
      tick_ff  <= nxt_tick;
    end
  end

  assign sample_tick = tick_ff;

endmodule

// file: hdl/ubc_uart_ctrl.sv
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
// Overview of operation
// - With address detect on, a received word whose address bit (bit 7 in 8-bit, bit 8 in 9-bit format) is one counts as an address.
// - In address detect mode an address word raises a receive interrupt when receive interrupts are enabled.
// - In address detect mode a word whose address bit is zero is dropped and raises nothing.
// - The high speed select bit picks the fast baud mode when one and the slow mode when zero.
// - With the receiver enable low the receiver is idle, its buffer empty and the receive pin free for port use.
// - Clearing the receiver enable mid-word aborts that word and resets the receiver at once.
// - With the transmitter enable low the transmitter is idle, its buffer empty and the transmit pin returned to port logic.
// - Only with both transmitter enable and port enable high does the transmitter drive the transmit pin.
// - Clearing the transmitter enable mid-frame stops the frame at once and resets the transmitter.
// - Bit timing comes from a dedicated free running 8-bit timer set by the divisor and speed select.
// - The bit rate is the clock over 64(N+1) in slow mode and over 16(N+1) in fast mode.
// - The divisor is an unsigned 0 to 255 value written by software and used directly.
// - Clearing port enable empties the buffers, drops any character, resets the baud counter and frees both pins.
// - With receive interrupts enabled an overrun or new receive data raises the serial interrupt.
module ubc_uart_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        rxd_pin,
  input  wire logic        port_tx_out,
  input  wire logic        port_tx_oe,
  output logic             txd_out,
  output logic             txd_oe,
  output logic             rx_pin_claimed,
  output logic             irq
);

  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } ubc_rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'h1,
    TX_SHIFT = 2'h2
  } ubc_tx_state_t;

  // Bus and register state.
  logic [ubc_pkg::CTRL_W-1:0] ctrl_ff,   nxt_ctrl;
  logic [7:0]                 baud_ff,   nxt_baud;
  logic [ubc_pkg::ST_W-1:0]   status_ff, nxt_status;
  logic [ubc_pkg::ST_W-1:0]   mask_ff,   nxt_mask;
  logic [8:0]                 txhold_ff, nxt_txhold;
  logic                       txfull_ff, nxt_txfull;
  logic [8:0]                 rxbuf_ff,  nxt_rxbuf;
  logic                       rxfull_ff, nxt_rxfull;
  logic                       wr_ph_ff,  nxt_wr_ph;
  logic [7:0]                 wr_ofs_ff, nxt_wr_ofs;
  logic [31:0]                rdata_ff,  nxt_rdata;
  // Transmitter state.
  ubc_tx_state_t              tx_st_ff,  nxt_tx_st;
  logic [10:0]                tx_sh_ff,  nxt_tx_sh;
  logic [3:0]                 tx_bit_ff, nxt_tx_bit;
  logic [3:0]                 tx_tk_ff,  nxt_tx_tk;
  logic                       tx_line_ff, nxt_tx_line;
  // Receiver state.
  ubc_rx_state_t              rx_st_ff,  nxt_rx_st;
  logic [8:0]                 rx_sh_ff,  nxt_rx_sh;
  logic [3:0]                 rx_bit_ff, nxt_rx_bit;
  logic [3:0]                 rx_tk_ff,  nxt_rx_tk;
  logic                       rx_s1_ff,  rx_s2_ff, rx_s3_ff;

  logic       port_en, tx_en, rx_en, nine_bit, tx_run, rx_run, tick;
  logic       addr_take, tx_load, rx_done, rx_keep, rx_addr_bit, rx_read;
  logic [8:0] rx_word;
  logic [3:0] frame_last;

  assign port_en  = ctrl_ff[ubc_pkg::CB_PORT_EN];
  assign tx_en    = ctrl_ff[ubc_pkg::CB_TX_EN];
  assign rx_en    = ctrl_ff[ubc_pkg::CB_RX_EN];
  assign nine_bit = ctrl_ff[ubc_pkg::CB_NINE_BIT];
  assign tx_run   = port_en && tx_en;
  assign rx_run   = port_en && rx_en;

  ubc_baud_gen #(
    .DIV_W (8)
  ) u_baud (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .clear       (!port_en),
    .high_speed  (ctrl_ff[ubc_pkg::CB_HIGH_SPEED]),
    .divisor     (baud_ff),
    .sample_tick (tick)
  );

  // Pin ownership: a disabled direction hands its pin back to the port logic.
  assign txd_out        = tx_run ? tx_line_ff : port_tx_out;
  assign txd_oe         = tx_run ? 1'b1 : port_tx_oe;
  assign rx_pin_claimed = rx_run;

  // Single slave: always OKAY, one wait state only in a write data phase.
  assign hreadyout = !wr_ph_ff;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_ff;
  assign addr_take = hsel && hready && htrans[ubc_pkg::HTRANS_ACTIVE];
  assign rx_read   = addr_take && !hwrite && (haddr[7:0] == ubc_pkg::OFS_RXDATA);

  // Interrupt output; receive events only count while receive interrupts are on.
  always_comb begin
    logic [ubc_pkg::ST_W-1:0] gate;
    gate = mask_ff;
    if (!ctrl_ff[ubc_pkg::CB_RX_IRQ_EN]) begin
      gate[ubc_pkg::SB_RX_AVAIL]  = 1'b0;
      gate[ubc_pkg::SB_OVERRUN]   = 1'b0;
      gate[ubc_pkg::SB_ADDR_RCVD] = 1'b0;
    end
    irq = |(status_ff & gate);
  end

  // Register file and bus next state. Hardware sets win over a same-cycle status write clear; a port disable clears last.
  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_baud   = baud_ff;
    nxt_status = status_ff;
    nxt_mask   = mask_ff;
    nxt_txhold = txhold_ff;
    nxt_txfull = txfull_ff;
    nxt_rxbuf  = rxbuf_ff;
    nxt_rxfull = rxfull_ff;
    nxt_wr_ph  = 1'b0;
    nxt_wr_ofs = wr_ofs_ff;
    nxt_rdata  = rdata_ff;
    // Write data phase: hwdata is applied at the end of the first data cycle.
    if (wr_ph_ff) begin
      case (wr_ofs_ff)
        ubc_pkg::OFS_CTRL:   nxt_ctrl = hwdata[ubc_pkg::CTRL_W-1:0];
        ubc_pkg::OFS_BAUD:   nxt_baud = hwdata[7:0];
        ubc_pkg::OFS_STATUS: nxt_status = status_ff & ~hwdata[ubc_pkg::ST_W-1:0];
        ubc_pkg::OFS_MASK:   nxt_mask = hwdata[ubc_pkg::ST_W-1:0];
        ubc_pkg::OFS_TXDATA: begin
          // A write to a full holding register is dropped, as it would overwrite data.
          if (!txfull_ff && tx_run) begin
            nxt_txhold = hwdata[8:0];
            nxt_txfull = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // Address phase: latch writes, prepare read data.
    if (addr_take) begin
      nxt_wr_ph  = hwrite;
      nxt_wr_ofs = haddr[7:0];
      nxt_rdata  = 32'h0;
      if (!hwrite) begin
        case (haddr[7:0])
          ubc_pkg::OFS_CTRL:   nxt_rdata[ubc_pkg::CTRL_W-1:0] = ctrl_ff;
          ubc_pkg::OFS_BAUD:   nxt_rdata[7:0] = baud_ff;
          ubc_pkg::OFS_STATUS: nxt_rdata[ubc_pkg::ST_W-1:0] = status_ff;
          ubc_pkg::OFS_MASK:   nxt_rdata[ubc_pkg::ST_W-1:0] = mask_ff;
          ubc_pkg::OFS_RXDATA: nxt_rdata[8:0] = rxbuf_ff;
          ubc_pkg::OFS_STATE:  nxt_rdata[3:0] = {!rx_st_ff[0], !tx_st_ff[0],
                                                 txfull_ff, rxfull_ff};
          default:             nxt_rdata = 32'h0;
        endcase
      end
    end
    if (rx_read) begin
      nxt_rxfull = 1'b0;
    end
    // Holding register handed to the shifter.
    if (tx_load) begin
      nxt_txfull = 1'b0;
      nxt_status[ubc_pkg::SB_TX_EMPTY] = 1'b1;
    end
    // Completed word: store, flag overrun, or discard a data word in address mode.
    if (rx_done && rx_keep) begin
      if (rxfull_ff && !rx_read) begin
        nxt_status[ubc_pkg::SB_OVERRUN] = 1'b1;
      end else begin
        nxt_rxbuf  = rx_word;
        nxt_rxfull = 1'b1;
        nxt_status[ubc_pkg::SB_RX_AVAIL] = 1'b1;
      end
      if (ctrl_ff[ubc_pkg::CB_ADDR_DET]) begin
        nxt_status[ubc_pkg::SB_ADDR_RCVD] = 1'b1;
      end
    end
    // Disabled directions drop their buffered words.
    if (!tx_run) begin
      nxt_txfull = 1'b0;
    end
    if (!rx_run) begin
      nxt_rxfull = 1'b0;
    end
    // Port disable clears both direction enables and every flag. The next
    // value is tested so that one write can turn the port and a direction on.
    if (!nxt_ctrl[ubc_pkg::CB_PORT_EN]) begin
      nxt_ctrl[ubc_pkg::CB_TX_EN] = 1'b0;
      nxt_ctrl[ubc_pkg::CB_RX_EN] = 1'b0;
      nxt_status = '0;
    end
  end

  // Registers of the register file and bus.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_ff   <= ubc_pkg::CTRL_RST;
      baud_ff   <= ubc_pkg::BAUD_RST;
      status_ff <= '0;
      mask_ff   <= ubc_pkg::MASK_RST;
      txhold_ff <= 9'h000;
      txfull_ff <= 1'b0;
      rxbuf_ff  <= 9'h000;
      rxfull_ff <= 1'b0;
      wr_ph_ff  <= 1'b0;
      wr_ofs_ff <= 8'h00;
      rdata_ff  <= 32'h0;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      baud_ff   <= nxt_baud;
      status_ff <= nxt_status;
      mask_ff   <= nxt_mask;
      txhold_ff <= nxt_txhold;
      txfull_ff <= nxt_txfull;
      rxbuf_ff  <= nxt_rxbuf;
      rxfull_ff <= nxt_rxfull;
      wr_ph_ff  <= nxt_wr_ph;
      wr_ofs_ff <= nxt_wr_ofs;
      rdata_ff  <= nxt_rdata;
    end
  end

  // Transmitter: start, 8 or 9 data bits LSB first, one stop bit.
  assign frame_last = nine_bit ? 4'ha : 4'h9;
  assign tx_load    = tx_run && (tx_st_ff == TX_IDLE) && txfull_ff;

  always_comb begin
    nxt_tx_st   = tx_st_ff;
    nxt_tx_sh   = tx_sh_ff;
    nxt_tx_bit  = tx_bit_ff;
    nxt_tx_tk   = tx_tk_ff;
    nxt_tx_line = tx_line_ff;
    case (tx_st_ff)
      TX_IDLE: begin
        nxt_tx_line = 1'b1;
        if (tx_load) begin
          nxt_tx_sh   = nine_bit ? {1'b1, txhold_ff, 1'b0}
                                 : {2'b11, txhold_ff[7:0], 1'b0};
          nxt_tx_bit  = 4'h0;
          nxt_tx_tk   = 4'h0;
          nxt_tx_st   = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        nxt_tx_line = tx_sh_ff[0];
        if (tick) begin
          nxt_tx_tk = tx_tk_ff + 4'h1;
          if (tx_tk_ff == ubc_pkg::TICK_LAST) begin
            nxt_tx_sh  = {1'b1, tx_sh_ff[10:1]};
            nxt_tx_bit = tx_bit_ff + 4'h1;
            if (tx_bit_ff == frame_last) begin
              nxt_tx_st = TX_IDLE;
            end
          end
        end
      end
      default: nxt_tx_st = TX_IDLE;
    endcase
    // Losing either enable ends the frame on this very cycle.
    if (!tx_run) begin
      nxt_tx_st   = TX_IDLE;
      nxt_tx_line = 1'b1;
      nxt_tx_tk   = 4'h0;
      nxt_tx_bit  = 4'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_st_ff   <= TX_IDLE;
      tx_sh_ff   <= 11'h7ff;
      tx_bit_ff  <= 4'h0;
      tx_tk_ff   <= 4'h0;
      tx_line_ff <= 1'b1;
    end else begin
      tx_st_ff   <= nxt_tx_st;
      tx_sh_ff   <= nxt_tx_sh;
      tx_bit_ff  <= nxt_tx_bit;
      tx_tk_ff   <= nxt_tx_tk;
      tx_line_ff <= nxt_tx_line;
    end
  end

  // Receive pin synchroniser; the third stage only serves the start edge detector.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      rx_s3_ff <= 1'b1;
    end else begin
      rx_s1_ff <= rxd_pin;
      rx_s2_ff <= rx_s1_ff;
      rx_s3_ff <= rx_s2_ff;
    end
  end

  // Word assembly and address detection; bits enter at the top, LSB first.
  assign rx_word     = nine_bit ? rx_sh_ff : {1'b0, rx_sh_ff[8:1]};
  assign rx_addr_bit = nine_bit ? rx_word[8] : rx_word[7];
  assign rx_keep     = !ctrl_ff[ubc_pkg::CB_ADDR_DET] || rx_addr_bit;
  assign rx_done     = rx_run && (rx_st_ff == RX_STOP) && tick &&
                       (rx_tk_ff == ubc_pkg::TICK_LAST) && rx_s2_ff;

  always_comb begin
    nxt_rx_st  = rx_st_ff;
    nxt_rx_sh  = rx_sh_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_tk  = rx_tk_ff;
    if (tick) begin
      nxt_rx_tk = rx_tk_ff + 4'h1;
    end
    case (rx_st_ff)
      RX_IDLE: begin
        nxt_rx_tk = 4'h0;
        if (rx_s3_ff && !rx_s2_ff) begin
          nxt_rx_st = RX_START;
        end
      end
      RX_START: begin
        // Start bit checked at mid-bit; a short glitch returns to idle.
        if (tick && (rx_tk_ff == ubc_pkg::TICK_MID)) begin
          nxt_rx_tk  = 4'h0;
          nxt_rx_bit = 4'h0;
          nxt_rx_st  = rx_s2_ff ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (tick && (rx_tk_ff == ubc_pkg::TICK_LAST)) begin
          nxt_rx_sh  = {rx_s2_ff, rx_sh_ff[8:1]};
          nxt_rx_bit = rx_bit_ff + 4'h1;
          if (rx_bit_ff == (nine_bit ? 4'h8 : 4'h7)) begin
            nxt_rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        // A low stop bit is a framing fault and the word is not kept.
        if (tick && (rx_tk_ff == ubc_pkg::TICK_LAST)) begin
          nxt_rx_st = RX_IDLE;
        end
      end
      default: nxt_rx_st = RX_IDLE;
    endcase
    if (!rx_run) begin
      nxt_rx_st  = RX_IDLE;
      nxt_rx_tk  = 4'h0;
      nxt_rx_bit = 4'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_st_ff  <= RX_IDLE;
      rx_sh_ff  <= 9'h000;
      rx_bit_ff <= 4'h0;
      rx_tk_ff  <= 4'h0;
    end else begin
      rx_st_ff  <= nxt_rx_st;
      rx_sh_ff  <= nxt_rx_sh;
      rx_bit_ff <= nxt_rx_bit;
      rx_tk_ff  <= nxt_rx_tk;
    end
  end

  // Transfer size is always a whole word on this bus; hsize is accepted and not decoded.
  logic unused_hsize;
  assign unused_hsize = ^hsize;

endmodule

// file: dv/ubc_uart_ctrl_props.sv
`timescale 1ns/1ns
// Pin ownership, interrupt masking and bus wait states seen from the ports.
// Control effects are judged in the cycle after the write data cycle,
// because a register only lands at the end of that cycle.
module ubc_uart_ctrl_props (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        port_tx_out,
  input wire logic        port_tx_oe,
  input wire logic        txd_out,
  input wire logic        txd_oe,
  input wire logic        rx_pin_claimed,
  input wire logic        irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // An address phase taken by the slave.
  sequence s_take(logic wr);
    hsel && hready && htrans[1] && (hwrite == wr);
  endsequence
  // A write to one register, ending in its data cycle.
  sequence s_wr(logic [7:0] ofs);
    hsel && hready && htrans[1] && hwrite && (haddr[7:0] == ofs) ##1 1'b1;
  endsequence

  property p_rd_fast;
    s_take(1'b0) |=> hreadyout;
  endproperty
  a_rd_fast: assert property (p_rd_fast) else $error("read stalled");
  property p_wr_wait;
    s_take(1'b1) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_wr_wait: assert property (p_wr_wait) else $error("write wait wrong");
  property p_tx_mux;
    (txd_out != port_tx_out) |-> txd_oe;
  endproperty
  a_tx_mux: assert property (p_tx_mux) else $error("tx pin driven unowned");
  property p_port_off;
    s_wr(ubc_pkg::OFS_CTRL) ##0 !hwdata[ubc_pkg::CB_PORT_EN] |=> !rx_pin_claimed
      && (txd_oe == port_tx_oe) && (txd_out == port_tx_out);
  endproperty
  a_port_off: assert property (p_port_off) else $error("pins kept at port off");
  property p_rx_off;
    s_wr(ubc_pkg::OFS_CTRL) ##0 !hwdata[ubc_pkg::CB_RX_EN] |=> !rx_pin_claimed;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx pin kept");
  property p_tx_off;
    s_wr(ubc_pkg::OFS_CTRL) ##0 !hwdata[ubc_pkg::CB_TX_EN]
      |=> (txd_oe == port_tx_oe) && (txd_out == port_tx_out);
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx pin kept");
  property p_tx_on;
    s_wr(ubc_pkg::OFS_CTRL) ##0 (hwdata[1:0] == 2'h3) |=> txd_oe;
  endproperty
  a_tx_on: assert property (p_tx_on) else $error("tx pin not taken");
  property p_rx_on;
    s_wr(ubc_pkg::OFS_CTRL) ##0 hwdata[0] && hwdata[2] |=> rx_pin_claimed;
  endproperty
  a_rx_on: assert property (p_rx_on) else $error("rx pin not taken");
  property p_mask_off;
    s_wr(ubc_pkg::OFS_MASK) ##0 (hwdata[3:0] == 4'h0) |=> !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq while masked");
endmodule

bind ubc_uart_ctrl ubc_uart_ctrl_props ubc_uart_ctrl_props_i (.sys_clk(sys_clk), .rst(rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .port_tx_out(port_tx_out),
  .port_tx_oe(port_tx_oe), .txd_out(txd_out), .txd_oe(txd_oe),
  .rx_pin_claimed(rx_pin_claimed), .irq(irq));

// file: dv/ubc_remote_dev.sv
`timescale 1ns/1ns
// Remote serial device: sends frames on the receive line and decodes the
// transmit line. The line idles high between frames, as a real link does.
module ubc_remote_dev (
  input  wire logic sys_clk,
  input  wire logic txd_out,
  input  wire logic txd_oe,
  output logic      rxd_pin
);
  initial rxd_pin = 1'b1;

  // Start bit, nb data bits LSB first, one stop bit, p clocks per bit.
  task automatic send(input logic [8:0] w, input int nb, input int p);
    for (int i = -1; i <= nb; i++) begin
      rxd_pin <= (i < 0) ? 1'b0 : (i == nb) ? 1'b1 : w[i];
      repeat (p) @(posedge sys_clk);
    end
    repeat (24) @(posedge sys_clk);
  endtask

  // Takes the first data bit's length as the bit time, so that a start bit
  // not aligned to a tick cannot skew it; that bit must therefore be one.
  task automatic recv(output logic [8:0] w, output int c);
    int k;
    int lim;
    w = 9'h1;
    for (k = 0; k < 9000 && !(txd_oe && !txd_out); k++) @(negedge sys_clk);
    lim = (k == 9000) ? 1 : 0;
    for (k = 0; k < 9000 && !txd_out; k++) @(negedge sys_clk);
    if (k == 9000) lim = 1;
    for (k = 0; k < 9000 && txd_out; k++) @(negedge sys_clk);
    // A bound that runs out is reported as a negative bit time.
    c = (k == 9000 || lim != 0) ? -1 : k;
    repeat (c / 2) @(negedge sys_clk);
    for (k = 1; k < 8; k++) begin
      w[k] = txd_out;
      repeat (c) @(negedge sys_clk);
    end
  endtask
endmodule

// file: dv/test_uart_baud_and_enable_control.sv
`timescale 1ns/1ns
module test_uart_baud_and_enable_control;
  logic        sys_clk, rst, hsel, hwrite, hreadyout, hresp, rxd_pin;
  logic        port_tx_out, port_tx_oe, txd_out, txd_oe, rx_pin_claimed, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [8:0]  w;
  logic [4:0]  pv;
  int          n_fail = 0;
  int          compares = 0;
  int          c;
  int          dv[3] = '{0, 255, 1};
  bit          hs[3] = '{1, 1, 0};

  assign pv = {hresp, txd_oe, irq, rx_pin_claimed, txd_out};

  ubc_uart_ctrl ubc_uart_ctrl_i (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxd_pin(rxd_pin),
    .port_tx_out(port_tx_out), .port_tx_oe(port_tx_oe), .txd_out(txd_out),
    .txd_oe(txd_oe), .rx_pin_claimed(rx_pin_claimed), .irq(irq));
  ubc_remote_dev ubc_remote_dev_i (.sys_clk(sys_clk), .txd_out(txd_out), .txd_oe(txd_oe),
    .rxd_pin(rxd_pin));

  task automatic conclude();
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // Holds the phase until ready is seen high; sampled mid-cycle to avoid races.
  task automatic wait_rdy();
    bit r;
    for (int k = 0; k < 50; k++) begin
      @(negedge sys_clk);
      r = hreadyout;
      rd = hrdata;
      @(posedge sys_clk);
      if (r)
        return;
    end
    n_fail++;
    conclude();
  endtask

  // One single transfer: address phase, then data phase.
  task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr_en;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdm(input string n, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(n, rd & m, e);
  endtask

  // Pin values are looked at mid-cycle, once every edge has settled.
  task automatic pin(input string n, input int idx, input logic e);
    @(negedge sys_clk);
    check(n, 32'(pv[idx]), 32'(e));
    @(posedge sys_clk);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Cuts a hang short.
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_fail++;
    conclude();
  end

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    port_tx_out = 1'b1;
    port_tx_oe = 1'b0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    // Reset values, an unmapped place and the top of the divisor range.
    rdm("ctrl", ubc_pkg::OFS_CTRL, 32'hffffffff, 32'(ubc_pkg::CTRL_RST));
    rdm("baud", ubc_pkg::OFS_BAUD, 32'hffffffff, 32'(ubc_pkg::BAUD_RST));
    rdm("mask", ubc_pkg::OFS_MASK, 32'hffffffff, 32'(ubc_pkg::MASK_RST));
    wr(8'h1c, 32'hffffffff);
    rdm("unmapped", 8'h1c, 32'hffffffff, 32'h0);
    wr(ubc_pkg::OFS_BAUD, 32'hff);
    rdm("baud max", ubc_pkg::OFS_BAUD, 32'hffffffff, 32'hff);
    pin("okay resp", 4, 1'b0);
    // Bit time in both speed modes; port off first so the counter reloads.
    for (int i = 0; i < 3; i++) begin
      wr(ubc_pkg::OFS_CTRL, 32'h0);
      wr(ubc_pkg::OFS_BAUD, 32'(dv[i]));
      wr(ubc_pkg::OFS_CTRL, 32'h3 | (32'(hs[i]) << ubc_pkg::CB_HIGH_SPEED));
      fork
        ubc_remote_dev_i.recv(w, c);
        wr(ubc_pkg::OFS_TXDATA, 32'ha5);
      join
      // A silent transmit line ends the run as a failure.
      if (c < 0) begin
        n_fail++;
        conclude();
      end
      check("tx word", 32'(w), 32'ha5);
      check("bit clocks", 32'(c), 32'((hs[i] ? 16 : 64) * (dv[i] + 1)));
    end
    // Abort a frame with a second word held; nothing may resume afterwards.
    repeat (200) @(posedge sys_clk);
    wr(ubc_pkg::OFS_TXDATA, 32'h0);
    wr(ubc_pkg::OFS_TXDATA, 32'h0);
    repeat (300) @(posedge sys_clk);
    wr(ubc_pkg::OFS_CTRL, 32'h1);
    pin("tx pin", 0, port_tx_out);
    pin("tx oe off", 3, port_tx_oe);
    rdm("tx state", ubc_pkg::OFS_STATE, 32'h6, 32'h0);
    wr(ubc_pkg::OFS_CTRL, 32'h3);
    pin("tx oe on", 3, 1'b1);
    repeat (300) @(posedge sys_clk);
    pin("tx idle", 0, 1'b1);
    // Two words unread: first kept, overrun flagged, interrupt gated.
    wr(ubc_pkg::OFS_CTRL, 32'h0);
    wr(ubc_pkg::OFS_BAUD, 32'h0);
    wr(ubc_pkg::OFS_CTRL, 32'h65);
    wr(ubc_pkg::OFS_MASK, 32'h7);
    wr(ubc_pkg::OFS_STATUS, 32'hf);
    ubc_remote_dev_i.send(9'h3c, 8, 16);
    ubc_remote_dev_i.send(9'h81, 8, 16);
    rdm("rx flags", ubc_pkg::OFS_STATUS, 32'h7, 32'h3);
    pin("irq", 2, 1'b1);
    rdm("rx word", ubc_pkg::OFS_RXDATA, 32'h1ff, 32'h3c);
    wr(ubc_pkg::OFS_MASK, 32'h0);
    pin("irq masked", 2, 1'b0);
    wr(ubc_pkg::OFS_MASK, 32'h7);
    wr(ubc_pkg::OFS_CTRL, 32'h25);
    pin("irq gated", 2, 1'b0);
    wr(ubc_pkg::OFS_CTRL, 32'h65);
    pin("irq again", 2, 1'b1);
    wr(ubc_pkg::OFS_STATUS, 32'h7);
    pin("irq cleared", 2, 1'b0);
    // Address detect in 9-bit and 8-bit format.
    wr(ubc_pkg::OFS_CTRL, 32'h7d);
    ubc_remote_dev_i.send(9'h0a5, 9, 16);
    rdm("data dropped", ubc_pkg::OFS_STATE, 32'h1, 32'h0);
    pin("no irq", 2, 1'b0);
    ubc_remote_dev_i.send(9'h1a5, 9, 16);
    pin("addr irq", 2, 1'b1);
    rdm("addr flags", ubc_pkg::OFS_STATUS, 32'h7, 32'h5);
    rdm("addr word", ubc_pkg::OFS_RXDATA, 32'h1ff, 32'h1a5);
    wr(ubc_pkg::OFS_STATUS, 32'h7);
    wr(ubc_pkg::OFS_CTRL, 32'h75);
    ubc_remote_dev_i.send(9'h3c, 8, 16);
    rdm("8-bit dropped", ubc_pkg::OFS_STATE, 32'h1, 32'h0);
    ubc_remote_dev_i.send(9'hbc, 8, 16);
    rdm("8-bit addr", ubc_pkg::OFS_RXDATA, 32'h1ff, 32'hbc);
    // Receiver switched off mid-word and back on: the word must not land.
    wr(ubc_pkg::OFS_CTRL, 32'h65);
    wr(ubc_pkg::OFS_STATUS, 32'h7);
    fork
      ubc_remote_dev_i.send(9'h0, 8, 16);
      begin
        repeat (60) @(posedge sys_clk);
        wr(ubc_pkg::OFS_CTRL, 32'h61);
        pin("rx pin", 1, 1'b0);
      end
    join
    wr(ubc_pkg::OFS_CTRL, 32'h65);
    rdm("rx aborted", ubc_pkg::OFS_STATE, 32'h9, 32'h0);
    rdm("rx no data", ubc_pkg::OFS_STATUS, 32'h1, 32'h0);
    // Port off with a word held: buffer and flags emptied.
    ubc_remote_dev_i.send(9'h3c, 8, 16);
    wr(ubc_pkg::OFS_CTRL, 32'h0);
    rdm("off state", ubc_pkg::OFS_STATE, 32'hf, 32'h0);
    rdm("off flags", ubc_pkg::OFS_STATUS, 32'h7, 32'h0);
    pin("off irq", 2, 1'b0);
    conclude();
  end
endmodule
